// [include/adc_port_defines.vh]
// Constants for the converter sample output port
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

// Result word
`define ADC_DATA_W 13
`define ADC_IN_W 14
`define ADC_LATENCY 4
`define ADC_MSB_POS 12
`define ADC_LSB_POS 0

// Full scale, two's complement input range
`define ADC_FS_MAX 14'sh0FFF
`define ADC_FS_MIN -14'sh1000
`define ADC_MIDSCALE 13'h1000

// Reset values
`define ADC_WORD_RST 13'h1000
`define ADC_FLAG_RST 1'h0
`define ADC_STROBE_RST 1'h0

// Sample clock timing
`define ADC_CLK_PERIOD_NS 4
`define ADC_CLK_HIGH_NS 2
`define ADC_CLK_LOW_NS 2
`define ADC_SYNC_STAGES 2

`endif

// [core/result_skid_buffer.v]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module result_skid_buffer #(
  parameter WIDTH = 14
) (
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:1];
  reg wrPtr_reg;
  reg rdPtr_reg;
  reg [1:0] count_reg;
  wire doPush;
  wire doPop;

  assign inReady = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData = mem[rdPtr_reg];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  ////////////////////////////////////////////////////////////////
  // Storage
  always @(posedge sys_clk)
  begin
    if (doPush)
    begin
      mem[wrPtr_reg] <= inData;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pointers and occupancy
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_reg <= 1'h0;
      rdPtr_reg <= 1'h0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (doPop)
      begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      if (doPush && !doPop)
      begin
        count_reg <= count_reg + 2'h1;
      end
      else if (doPop && !doPush)
      begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule

// [core/adc_sample_output_port.v]
// Converter digital side: sample pipeline, output word, strobe
`timescale 1ns/100ps
`include "adc_port_defines.vh"
module adc_sample_output_port #(
  parameter DATA_W = `ADC_DATA_W,
  parameter IN_W = `ADC_IN_W,
  parameter LATENCY = `ADC_LATENCY
) (
  input wire sys_clk,
  input wire rst,
  input wire sampleClk,
  input wire [IN_W-1:0] analogSignalInput,
  input wire resultAccept,
  output reg [DATA_W-1:0] resultWord,
  output reg overRangeFlag,
  output reg resultReadyStrobe,
  output reg resultValid,
  output reg bufferReady,
  output reg sampleOverrun
);
  localparam BUF_W = DATA_W + 1;

  ////////////////////////////////////////////////////////////////
  // Conversion helpers
  function aboveFullScale;
    input [IN_W-1:0] raw;
    begin
      aboveFullScale = ($signed(raw) > $signed(`ADC_FS_MAX));
    end
  endfunction

  function belowFullScale;
    input [IN_W-1:0] raw;
    begin
      belowFullScale = ($signed(raw) < $signed(`ADC_FS_MIN));
    end
  endfunction

  function overRange;
    input [IN_W-1:0] raw;
    begin
      overRange = aboveFullScale(raw) || belowFullScale(raw);
    end
  endfunction

  function [DATA_W-1:0] toOffsetBinary;
    input [IN_W-1:0] raw;
    reg [IN_W-1:0] clamped;
    begin
      clamped = raw;
      if (aboveFullScale(raw))
      begin
        clamped = `ADC_FS_MAX;
      end
      else if (belowFullScale(raw))
      begin
        clamped = `ADC_FS_MIN;
      end
      // Mid-scale maps to the middle code
      toOffsetBinary = clamped[DATA_W-1:0] ^ `ADC_MIDSCALE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Sample clock and input synchronisers
  reg clkSync1_reg;
  reg clkSync2_reg;
  reg clkLast_reg;
  reg [IN_W-1:0] ainSync1_reg;
  reg [IN_W-1:0] ainSync2_reg;
  wire clkRise;
  wire clkFall;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clkSync1_reg <= 1'h0;
      clkSync2_reg <= 1'h0;
      clkLast_reg <= 1'h0;
    end
    else
    begin
      clkSync1_reg <= sampleClk;
      clkSync2_reg <= clkSync1_reg;
      clkLast_reg <= clkSync2_reg;
    end
  end

  // Input word follows the clock through the same two stages
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ainSync1_reg <= {IN_W{1'b0}};
      ainSync2_reg <= {IN_W{1'b0}};
    end
    else
    begin
      ainSync1_reg <= analogSignalInput;
      ainSync2_reg <= ainSync1_reg;
    end
  end

  assign clkRise = clkSync2_reg & ~clkLast_reg;
  assign clkFall = ~clkSync2_reg & clkLast_reg;

  ////////////////////////////////////////////////////////////////
  // Conversion pipeline, one stage per sample clock rise
  reg [BUF_W-1:0] stage_reg [0:LATENCY-1];
  reg [LATENCY-1:0] stageValid_reg;
  wire [BUF_W-1:0] sampleEntry;
  integer i;

  assign sampleEntry = {overRange(ainSync2_reg), toOffsetBinary(ainSync2_reg)};

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stageValid_reg <= {LATENCY{1'b0}};
      for (i = 0; i < LATENCY; i = i + 1)
      begin
        stage_reg[i] <= {BUF_W{1'b0}};
      end
    end
    else if (clkRise)
    begin
      // New sample on every rise
      stage_reg[0] <= sampleEntry;
      stageValid_reg <= {stageValid_reg[LATENCY-2:0], 1'b1};
      for (i = 1; i < LATENCY; i = i + 1)
      begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output buffer, loaded on the fourth rise after the sample
  wire pushValid;
  wire bufInReady;
  wire [BUF_W-1:0] bufOutData;
  wire bufOutValid;
  wire popReady;

  assign pushValid = clkRise & stageValid_reg[LATENCY-1];
  assign popReady = clkFall & resultAccept;

  result_skid_buffer #(
    .WIDTH(BUF_W)
  ) resultBuffer (
    .sys_clk(sys_clk),
    .rst(rst),
    .inData(stage_reg[LATENCY-1]),
    .inValid(pushValid),
    .inReady(bufInReady),
    .outData(bufOutData),
    .outValid(bufOutValid),
    .outReady(popReady)
  );

  ////////////////////////////////////////////////////////////////
  // Output word, flag and strobe, next values
  reg [DATA_W-1:0] resultWord_next;
  reg overRangeFlag_next;
  reg resultReadyStrobe_next;
  reg resultValid_next;
  reg sampleOverrun_next;

  always @*
  begin
    resultWord_next = resultWord;
    overRangeFlag_next = overRangeFlag;
    resultReadyStrobe_next = resultReadyStrobe;
    resultValid_next = resultValid;
    sampleOverrun_next = sampleOverrun;
    // Word dropped when both entries are taken
    if (pushValid && !bufInReady)
    begin
      sampleOverrun_next = 1'h1;
    end
    // Strobe tracks the inverted sample clock
    if (clkRise)
    begin
      resultReadyStrobe_next = 1'h0;
    end
    else if (clkFall)
    begin
      resultReadyStrobe_next = 1'h1;
    end
    // Word and flag change only with the strobe rise
    if (popReady && bufOutValid)
    begin
      resultWord_next = bufOutData[DATA_W-1:0];
      overRangeFlag_next = bufOutData[DATA_W];
      resultValid_next = 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output registers
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      resultWord <= `ADC_WORD_RST;
      overRangeFlag <= `ADC_FLAG_RST;
      resultReadyStrobe <= `ADC_STROBE_RST;
      resultValid <= 1'h0;
      bufferReady <= 1'h1;
      sampleOverrun <= 1'h0;
    end
    else
    begin
      resultWord <= resultWord_next;
      overRangeFlag <= overRangeFlag_next;
      resultReadyStrobe <= resultReadyStrobe_next;
      resultValid <= resultValid_next;
      bufferReady <= bufInReady;
      sampleOverrun <= sampleOverrun_next;
    end
  end
endmodule

// [test/adc_port_asserts.sv]
// Checker for the sample output port
`timescale 1ns/100ps
module adc_port_asserts (
  input wire sys_clk,
  input wire rst,
  input wire sampleClk,
  input wire [12:0] resultWord,
  input wire overRangeFlag,
  input wire resultReadyStrobe,
  input wire resultValid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_word_at_rise: assert property ($changed(resultWord) |-> $rose(resultReadyStrobe))
    else $error("word moved");
  a_flag_at_rise: assert property ($changed(overRangeFlag) |-> $rose(resultReadyStrobe))
    else $error("flag moved");
  a_strobe_falls: assert property ($rose(sampleClk) |-> ##[1:5] !resultReadyStrobe)
    else $error("strobe fall late");
  a_strobe_rises: assert property ($fell(sampleClk) |-> ##[1:5] resultReadyStrobe)
    else $error("strobe rise late");
  a_clamp_code: assert property (overRangeFlag |-> (resultWord == 13'h1FFF) || (resultWord == 13'h0000))
    else $error("clamp code");
  a_valid_sticky: assert property (resultValid |=> resultValid)
    else $error("valid lost");
  a_valid_start: assert property ($rose(resultValid) |-> $rose(resultReadyStrobe))
    else $error("valid start");
  c_over: cover property (overRangeFlag);
  c_first: cover property ($rose(resultValid));
  c_zero: cover property (resultWord == 13'h0000);
endmodule
bind adc_sample_output_port adc_port_asserts i_chk (.*);

// [test/adc_rx_model.sv]
// Sample clock source and result receiver
`timescale 1ns/100ps
module adc_rx_model (
  input wire [12:0] resultWord,
  input wire overRangeFlag,
  input wire resultReadyStrobe,
  input wire resultValid,
  output reg sampleClk,
  output wire resultAccept
);
  reg run = 1'b0;
  reg hold = 1'b0;
  reg [13:0] cap;
  event got;
  assign resultAccept = !hold;
  initial
  begin
    sampleClk = 1'b0;
    #6;
    forever #40 sampleClk = run & ~sampleClk;
  end
  always @(negedge resultReadyStrobe)
    if (resultValid)
    begin
      cap = {overRangeFlag, resultWord};
      -> got;
    end
endmodule

// [test/adc_sample_output_port_tb_top.sv]
// Bench for the sample output port
`timescale 1ns/100ps
module adc_sample_output_port_tb_top;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [13:0] analogSignalInput = 14'h0000;
  reg [13:0] smp [0:63];
  reg [13:0] tbl [0:5] = '{14'h0FFF, 14'h3000, 14'h1000, 14'h2000, 14'h0001, 14'h3FFF};
  wire [12:0] resultWord;
  wire sampleClk, resultAccept, overRangeFlag, resultReadyStrobe;
  wire resultValid, bufferReady, sampleOverrun;
  integer mismatches = 0;
  integer tests_run = 0;
  integer rc = 0;
  integer i;
  adc_sample_output_port i_dut (.*);
  adc_rx_model i_rx (.*);
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sampleClk)
  begin
    smp[rc] = analogSignalInput;
    rc = rc + 1;
  end
  function [13:0] enc(input [13:0] v);
    enc = (v[13] == v[12]) ? {1'b0, ~v[12], v[11:0]} : {1'b1, {13{~v[13]}}};
  endfunction
  task chk(input string n, input [17:0] e, input [17:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task stop_test;
  begin
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task t_reset(input integer w);
  begin
    i_rx.run = 1'b0;
    i_rx.hold = 1'b0;
    repeat (w) @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    rc = 0;
    chk("reset", 18'h05000, {resultValid, sampleOverrun, resultReadyStrobe, bufferReady,
      overRangeFlag, resultWord});
  end
  endtask
  task t_stream;
  begin
    i_rx.run = 1'b1;
    fork
      for (i = 0; i < 12; i = i + 1)
      begin
        @(negedge sampleClk);
        @(posedge sys_clk) #1 analogSignalInput = (i < 6) ? tbl[i] : 14'h0000;
      end
      repeat (8)
      begin
        @(i_rx.got);
        chk("result", enc(smp[rc - 6]), i_rx.cap);
      end
    join
  end
  endtask
  task t_stall;
  begin
    @(posedge sys_clk) #1 i_rx.hold = 1'b1;
    repeat (5) @(posedge sampleClk);
    repeat (4) @(posedge sys_clk);
    chk("overrun", 18'h2, {sampleOverrun, bufferReady});
    @(posedge sys_clk) #1 i_rx.hold = 1'b0;
    repeat (3) @(posedge sampleClk);
    chk("sticky", 18'h1, sampleOverrun);
  end
  endtask
  initial
  begin
    t_reset(0);
    t_stream;
    t_stall;
    t_reset(20);
    stop_test;
  end
  initial
  begin
    #20000;
    mismatches = mismatches + 1;
    stop_test;
  end
endmodule
